// ===== core/pcsrc_pkg.sv
// Constants and carriers for the PHY configuration, strap and reset control block
package pcsrc_pkg;
    // Register byte offsets on the Wishbone slave
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // Management address width
    localparam int MGMT_ADDR_W = 5;
    // Control field positions
    localparam int CTRL_FAST_EN_BIT = 0;
    localparam int CTRL_RCLK_EN_BIT = 1;
    localparam int CTRL_SW_DOWN_BIT = 2;
    localparam int CTRL_HOLD_DRIVE_BIT = 3;
    // Status field positions
    localparam int STAT_ADDR_LSB = 0;
    localparam int STAT_POWERED_DOWN_BIT = 8;
    localparam int STAT_REF_SEL_BIT = 9;
    localparam int STAT_SQUELCH_BIT = 10;
    localparam int STAT_HOLD_BIT = 11;
    localparam int STAT_IN_RESET_BIT = 12;
    // Control reset values
    localparam logic CTRL_FAST_EN_RST = 1'h0;
    localparam logic CTRL_RCLK_EN_RST = 1'h0;
    localparam logic CTRL_SW_DOWN_RST = 1'h0;
    localparam logic CTRL_HOLD_DRIVE_RST = 1'h0;
    // Synchroniser depth for pins
    localparam int SYNC_STAGES = 2;

    // Software control fields
    typedef struct packed {
        logic hold_drive;
        logic sw_down;
        logic rclk_en;
        logic fast_en;
    } pcsrc_ctrl_t;

    localparam pcsrc_ctrl_t CTRL_RST = '{
        hold_drive: CTRL_HOLD_DRIVE_RST,
        sw_down: CTRL_SW_DOWN_RST,
        rclk_en: CTRL_RCLK_EN_RST,
        fast_en: CTRL_FAST_EN_RST
    };

    // Pin levels entering from the board, synchronised as one group
    typedef struct packed {
        logic reset_n;
        logic hold;
        logic squelch;
        logic ref_sel;
        logic strap0;
        logic strap1;
        logic strap2;
        logic strap3;
        logic strap4;
    } pcsrc_pins_t;

    // Power sequencing states
    typedef enum logic [1:0] {PS_RESET, PS_DOWN, PS_UP} pcsrc_pstate_t;
endpackage

// ===== core/pcsrc_top.sv
// Configuration pins, strap latch, device reset and power hold control
`timescale 1ns/1ps
module pcsrc_top (
    input wire logic clk,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pcsrc_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [pcsrc_pkg::DATA_W-1:0] wb_dat_i,
    output logic [pcsrc_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Board pins
    input wire logic device_reset_n,
    input wire logic power_hold_sync_in,
    output logic power_hold_sync_out,
    output logic power_hold_sync_oe,
    input wire logic clk_squelch_in,
    input wire logic ref_frequency_select,
    input wire logic fast_link_failure_in,
    output logic fast_link_failure_out,
    output logic fast_link_failure_oe,
    input wire logic recovered_clock_in,
    output logic recovered_clock_out,
    output logic recovered_clock_oe,
    input wire logic mgmt_address_bit1_in,
    output logic mgmt_address_bit1_out,
    output logic mgmt_address_bit1_oe,
    input wire logic mgmt_address_bit3,
    input wire logic mgmt_address_bit4,
    // Core side, same clock
    input wire logic link_fail_event,
    input wire logic media_clock_src,
    output logic [pcsrc_pkg::MGMT_ADDR_W-1:0] mgmt_address,
    output logic phy_powered_down,
    output logic core_reset,
    output logic ref_freq_mode,
    output logic led_sync_restart
);
    pcsrc_pkg::pcsrc_pins_t pins_raw;
    pcsrc_pkg::pcsrc_pins_t sync1;
    pcsrc_pkg::pcsrc_pins_t pins;
    pcsrc_pkg::pcsrc_pstate_t state;
    pcsrc_pkg::pcsrc_pstate_t next_state;
    pcsrc_pkg::pcsrc_ctrl_t ctrl;
    pcsrc_pkg::pcsrc_ctrl_t next_ctrl;
    logic hold_prev;
    logic next_hold_prev;
    logic [pcsrc_pkg::MGMT_ADDR_W-1:0] next_mgmt_address;
    logic next_ref_freq_mode;
    logic next_powered_down;
    logic next_core_reset;
    logic next_led_sync_restart;
    logic next_fast_out;
    logic next_fast_oe;
    logic next_rclk_out;
    logic next_rclk_oe;
    logic next_hold_out;
    logic next_hold_oe;
    logic [pcsrc_pkg::DATA_W-1:0] next_dat;
    logic next_ack;
    logic bus_req;
    logic releasing;

    // Gather the pins so one synchroniser handles the whole group
    always_comb begin
        pins_raw = '{
            reset_n: device_reset_n,
            hold: power_hold_sync_in,
            squelch: clk_squelch_in,
            ref_sel: ref_frequency_select,
            strap0: fast_link_failure_in,
            strap1: mgmt_address_bit1_in,
            strap2: recovered_clock_in,
            strap3: mgmt_address_bit3,
            strap4: mgmt_address_bit4
        };
    end

    // Two-stage synchroniser; only the second stage feeds logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= '0;
            pins <= '0;
        end else begin
            sync1 <= pins_raw;
            pins <= sync1;
        end
    end

    // Reset release is a synchronised rising edge of the reset pin
    assign releasing = (state == pcsrc_pkg::PS_RESET) && pins.reset_n;

    // Power sequencing: reset dominates, then hold or software power-down
    always_comb begin
        next_state = state;
        unique case (state)
            pcsrc_pkg::PS_RESET: begin
                if (pins.reset_n) begin
                    next_state = pcsrc_pkg::PS_DOWN;
                end
            end
            pcsrc_pkg::PS_DOWN: begin
                if (!pins.reset_n) begin
                    next_state = pcsrc_pkg::PS_RESET;
                end else if (!pins.hold && !ctrl.sw_down) begin
                    next_state = pcsrc_pkg::PS_UP;
                end
            end
            pcsrc_pkg::PS_UP: begin
                if (!pins.reset_n) begin
                    next_state = pcsrc_pkg::PS_RESET;
                end else if (pins.hold || ctrl.sw_down) begin
                    next_state = pcsrc_pkg::PS_DOWN;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= pcsrc_pkg::PS_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Straps latch only at release, so later pin traffic cannot move the address
    always_comb begin
        next_mgmt_address = mgmt_address;
        next_ref_freq_mode = ref_freq_mode;
        if (releasing) begin
            next_mgmt_address = {pins.strap4, pins.strap3, pins.strap2,
                pins.strap1, pins.strap0};
            next_ref_freq_mode = pins.ref_sel;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mgmt_address <= '0;
            ref_freq_mode <= 1'h0;
        end else begin
            mgmt_address <= next_mgmt_address;
            ref_freq_mode <= next_ref_freq_mode;
        end
    end

    // Wishbone slave: one wait state, unmapped reads return zero
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_comb begin
        next_ctrl = ctrl;
        next_dat = '0;
        next_ack = bus_req;
        if (state == pcsrc_pkg::PS_RESET) begin
            next_ctrl = pcsrc_pkg::CTRL_RST;
        end else if (bus_req && wb_we_i && wb_sel_i[0]
                && wb_adr_i == pcsrc_pkg::CTRL_OFFSET) begin
            next_ctrl.fast_en = wb_dat_i[pcsrc_pkg::CTRL_FAST_EN_BIT];
            next_ctrl.rclk_en = wb_dat_i[pcsrc_pkg::CTRL_RCLK_EN_BIT];
            next_ctrl.sw_down = wb_dat_i[pcsrc_pkg::CTRL_SW_DOWN_BIT];
            next_ctrl.hold_drive = wb_dat_i[pcsrc_pkg::CTRL_HOLD_DRIVE_BIT];
        end
        if (bus_req && !wb_we_i) begin
            if (wb_adr_i == pcsrc_pkg::CTRL_OFFSET) begin
                next_dat[pcsrc_pkg::CTRL_FAST_EN_BIT] = ctrl.fast_en;
                next_dat[pcsrc_pkg::CTRL_RCLK_EN_BIT] = ctrl.rclk_en;
                next_dat[pcsrc_pkg::CTRL_SW_DOWN_BIT] = ctrl.sw_down;
                next_dat[pcsrc_pkg::CTRL_HOLD_DRIVE_BIT] = ctrl.hold_drive;
            end else if (wb_adr_i == pcsrc_pkg::STATUS_OFFSET) begin
                next_dat[pcsrc_pkg::STAT_ADDR_LSB +: pcsrc_pkg::MGMT_ADDR_W] = mgmt_address;
                next_dat[pcsrc_pkg::STAT_POWERED_DOWN_BIT] = phy_powered_down;
                next_dat[pcsrc_pkg::STAT_REF_SEL_BIT] = ref_freq_mode;
                next_dat[pcsrc_pkg::STAT_SQUELCH_BIT] = pins.squelch;
                next_dat[pcsrc_pkg::STAT_HOLD_BIT] = pins.hold;
                next_dat[pcsrc_pkg::STAT_IN_RESET_BIT] = (state == pcsrc_pkg::PS_RESET);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= pcsrc_pkg::CTRL_RST;
            wb_dat_o <= '0;
            wb_ack_o <= 1'h0;
        end else begin
            ctrl <= next_ctrl;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
        end
    end

    // Pin drivers and core controls; all registered so no glitch reaches a pin
    always_comb begin
        next_hold_prev = pins.hold;
        next_powered_down = (state != pcsrc_pkg::PS_UP);
        next_core_reset = (state == pcsrc_pkg::PS_RESET);
        // Hold release restarts LED timers in every chip on the same edge
        next_led_sync_restart = hold_prev && !pins.hold && pins.reset_n;
        // Dual-use pins float in reset so the board straps can be sampled
        next_fast_oe = (state != pcsrc_pkg::PS_RESET);
        next_fast_out = next_fast_oe && ctrl.fast_en && link_fail_event;
        next_rclk_oe = (state != pcsrc_pkg::PS_RESET);
        next_rclk_out = (state == pcsrc_pkg::PS_UP) && ctrl.rclk_en
            && !pins.squelch && media_clock_src;
        // Open-drain style: only ever drive the shared hold line high
        next_hold_oe = ctrl.hold_drive && (state != pcsrc_pkg::PS_RESET);
        next_hold_out = next_hold_oe;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_prev <= 1'h0;
            phy_powered_down <= 1'h1;
            core_reset <= 1'h1;
            led_sync_restart <= 1'h0;
            fast_link_failure_oe <= 1'h0;
            fast_link_failure_out <= 1'h0;
            recovered_clock_oe <= 1'h0;
            recovered_clock_out <= 1'h0;
            power_hold_sync_oe <= 1'h0;
            power_hold_sync_out <= 1'h0;
            mgmt_address_bit1_out <= 1'h0;
            mgmt_address_bit1_oe <= 1'h0;
        end else begin
            hold_prev <= next_hold_prev;
            phy_powered_down <= next_powered_down;
            core_reset <= next_core_reset;
            led_sync_restart <= next_led_sync_restart;
            fast_link_failure_oe <= next_fast_oe;
            fast_link_failure_out <= next_fast_out;
            recovered_clock_oe <= next_rclk_oe;
            recovered_clock_out <= next_rclk_out;
            power_hold_sync_oe <= next_hold_oe;
            power_hold_sync_out <= next_hold_out;
            // Address bit 1 pin is a strap only; never driven
            mgmt_address_bit1_out <= 1'h0;
            mgmt_address_bit1_oe <= 1'h0;
        end
    end

    a_hold_powers_down: assert property (@(posedge clk) disable iff (rst)
        (pins.hold && pins.reset_n && state != pcsrc_pkg::PS_RESET) |=> ##1 phy_powered_down)
        else $error("PHY not powered down while hold is high");

    a_hold_release_up: assert property (@(posedge clk) disable iff (rst)
        (state == pcsrc_pkg::PS_DOWN && pins.reset_n && !pins.hold && !ctrl.sw_down)
        |=> ##1 !phy_powered_down)
        else $error("PHY did not power up after hold release");

    a_led_sync_pulse: assert property (@(posedge clk) disable iff (rst)
        ($fell(pins.hold) && pins.reset_n) |=> led_sync_restart ##1 !led_sync_restart)
        else $error("LED restart pulse missing after hold release");

    a_reset_defaults: assert property (@(posedge clk) disable iff (rst)
        (state == pcsrc_pkg::PS_RESET) |=> (ctrl == pcsrc_pkg::CTRL_RST) && core_reset
        && phy_powered_down)
        else $error("Reset did not restore defaults");

    a_fast_reset_idle: assert property (@(posedge clk) disable iff (rst)
        (state == pcsrc_pkg::PS_RESET) |=> !fast_link_failure_oe && !fast_link_failure_out)
        else $error("Fast link failure pin active in reset");

    a_fast_disabled_low: assert property (@(posedge clk) disable iff (rst)
        (!ctrl.fast_en && state != pcsrc_pkg::PS_RESET) |=> fast_link_failure_oe
        && !fast_link_failure_out)
        else $error("Disabled fast link failure pin not held low");

    a_strap_latch: assert property (@(posedge clk) disable iff (rst)
        releasing |=> mgmt_address == {$past(pins.strap4), $past(pins.strap3),
        $past(pins.strap2), $past(pins.strap1), $past(pins.strap0)})
        else $error("Address not latched from straps at release");

    a_rclk_gate: assert property (@(posedge clk) disable iff (rst)
        (!ctrl.rclk_en || pins.squelch || state != pcsrc_pkg::PS_UP) |=> !recovered_clock_out)
        else $error("Recovered clock not held low");

    a_address_stable: assert property (@(posedge clk) disable iff (rst)
        (state != pcsrc_pkg::PS_RESET) |=> $stable(mgmt_address))
        else $error("Address changed outside reset release");

    a_ref_sel_latch: assert property (@(posedge clk) disable iff (rst)
        releasing |=> ref_freq_mode == $past(pins.ref_sel))
        else $error("Reference select not latched");

    a_bus_ack: assert property (@(posedge clk) disable iff (rst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Wishbone ack not single cycle");
endmodule

// ===== verification/pcsrc_board.sv
// Board controller model: device reset, strap pins, reference select, hold line
`timescale 1ns/1ps
module pcsrc_board #(
    parameter int STABLE_CYCLES = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_req,
    input wire logic [4:0] strap_val,
    input wire logic ref_sel_val,
    input wire logic hold_req,
    output logic device_reset_n,
    output logic [4:0] strap_pins,
    output logic ref_frequency_select,
    output logic hold_level
);
    int cnt;
    int post;
    // Release only after clock and supplies have been stable for a while
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            post <= 0;
            device_reset_n <= 1'h0;
        end else if (reset_req) begin
            cnt <= 0;
            post <= 0;
            device_reset_n <= 1'h0;
        end else if (cnt < STABLE_CYCLES) begin
            cnt <= cnt + 1;
        end else begin
            device_reset_n <= 1'h1;
            if (post < 4) post <= post + 1;
        end
    end
    // Straps held around release, then let go: pull-downs win, bit 0 floats elsewhere
    assign strap_pins = (!device_reset_n || post < 4) ? strap_val : {4'h0, ~strap_val[0]};
    assign ref_frequency_select = ref_sel_val;
    assign hold_level = hold_req;
endmodule

// ===== verification/phy_config_strap_reset_control_test.sv
// Self-checking bench for the configuration, strap and reset control block
`timescale 1ns/1ps
module phy_config_strap_reset_control_test;
    logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, device_reset_n, hold_out, hold_oe;
    logic [3:0] wb_adr_i, wb_sel_i, sel_val;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic squelch, ref_sel, fl_out, fl_oe, rc_out, rc_oe, b1_out, b1_oe, link_fail, media_clk;
    logic pwr_down, core_reset, ref_mode, led_restart, reset_req, ref_sel_val, hold_req, hold_level;
    logic [4:0] strap_val, strap_pins, mgmt_address;
    int mismatches, n_checks, pulses;
    // Rows: {select in, straps in, mode expected, address expected}
    logic [11:0] rows [5] = '{12'h000, 12'hFFF, 12'h555, 12'hAAA, 12'h451};
    // Shared lines: an enabled driver wins, otherwise the board's level
    wire logic fl_pin = fl_oe ? fl_out : strap_pins[0];
    wire logic rc_pin = rc_oe ? rc_out : strap_pins[2];
    wire logic b1_pin = b1_oe ? b1_out : strap_pins[1];
    wire logic hold_pin = hold_oe ? hold_out : hold_level;

    pcsrc_top pcsrc_top_inst (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .device_reset_n(device_reset_n),
        .power_hold_sync_in(hold_pin), .power_hold_sync_out(hold_out),
        .power_hold_sync_oe(hold_oe), .clk_squelch_in(squelch), .ref_frequency_select(ref_sel),
        .fast_link_failure_in(fl_pin), .fast_link_failure_out(fl_out),
        .fast_link_failure_oe(fl_oe), .recovered_clock_in(rc_pin), .recovered_clock_out(rc_out),
        .recovered_clock_oe(rc_oe), .mgmt_address_bit1_in(b1_pin),
        .mgmt_address_bit1_out(b1_out), .mgmt_address_bit1_oe(b1_oe),
        .mgmt_address_bit3(strap_pins[3]), .mgmt_address_bit4(strap_pins[4]),
        .link_fail_event(link_fail), .media_clock_src(media_clk), .mgmt_address(mgmt_address),
        .phy_powered_down(pwr_down), .core_reset(core_reset), .ref_freq_mode(ref_mode),
        .led_sync_restart(led_restart));
    pcsrc_board pcsrc_board_inst (.clk(clk), .rst(rst), .reset_req(reset_req),
        .strap_val(strap_val), .ref_sel_val(ref_sel_val), .hold_req(hold_req),
        .device_reset_n(device_reset_n), .strap_pins(strap_pins),
        .ref_frequency_select(ref_sel), .hold_level(hold_level));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Classic single cycle; waits for ack under a bound
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_sel_i <= sel_val;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (i = 0; i < 20 && wb_ack_o !== 1'h1; i++) @(posedge clk);
        if (i == 20) chk(32'h0, 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    task automatic dev_reset(input logic [4:0] s, input logic r);
        @(posedge clk);
        reset_req <= 1'h1;
        strap_val <= s;
        ref_sel_val <= r;
        cyc(6);
        reset_req <= 1'h0;
        cyc(20);
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        #50000;
        mismatches++;
        print_verdict();
    end
    initial begin
        rst = 1'h1;
        {wb_cyc_i, wb_stb_i, wb_we_i, squelch, link_fail, media_clk, hold_req} = 7'h0;
        {wb_sel_i, sel_val} = 8'hFF;
        {wb_adr_i, wb_dat_i, strap_val, ref_sel_val, reset_req} = 43'h1;
        cyc(2);
        rst <= 1'h0;
        cyc(2);
        chk(32'({pwr_down, core_reset}), 32'h3);
        wb(1'h0, pcsrc_pkg::CTRL_OFFSET, 32'h0);
        chk(rd, 32'h0);
        foreach (rows[k]) begin
            dev_reset(rows[k][10:6], rows[k][11]);
            chk(32'(mgmt_address), 32'(rows[k][4:0]));
            chk(32'(ref_mode), 32'(rows[k][5]));
            wb(1'h0, pcsrc_pkg::STATUS_OFFSET, 32'h0);
            chk(rd, (32'(rows[k][5]) << pcsrc_pkg::STAT_REF_SEL_BIT) | 32'(rows[k][4:0]));
        end
        link_fail <= 1'h1;
        media_clk <= 1'h1;
        wb(1'h1, pcsrc_pkg::CTRL_OFFSET, 32'h3);
        cyc(4);
        chk(32'({fl_oe, fl_out, rc_oe, rc_out}), 32'hF);
        chk(32'({b1_oe, b1_out}), 32'h0);
        squelch <= 1'h1;
        cyc(5);
        chk(32'(rc_out), 32'h0);
        // Squelch shows in status while the address stays as latched
        wb(1'h0, pcsrc_pkg::STATUS_OFFSET, 32'h0);
        chk(rd, (32'h1 << pcsrc_pkg::STAT_SQUELCH_BIT) | 32'h11);
        squelch <= 1'h0;
        wb(1'h1, pcsrc_pkg::CTRL_OFFSET, 32'h0);
        cyc(4);
        chk(32'({fl_oe, fl_out, rc_oe, rc_out}), 32'hA);
        wb(1'h1, pcsrc_pkg::CTRL_OFFSET, 32'h3);
        reset_req <= 1'h1;
        cyc(6);
        chk(32'({fl_oe, fl_out, rc_oe, rc_out, core_reset, pwr_down}), 32'h3);
        wb(1'h1, pcsrc_pkg::CTRL_OFFSET, 32'h3);
        // In reset the old address must still stand until the next release
        wb(1'h0, pcsrc_pkg::STATUS_OFFSET, 32'h0);
        chk(rd, (32'h1 << pcsrc_pkg::STAT_IN_RESET_BIT) | 32'h11
            | (32'h1 << pcsrc_pkg::STAT_POWERED_DOWN_BIT));
        reset_req <= 1'h0;
        cyc(20);
        wb(1'h0, pcsrc_pkg::CTRL_OFFSET, 32'h0);
        chk(rd, 32'h0);
        hold_req <= 1'h1;
        cyc(6);
        chk(32'(pwr_down), 32'h1);
        hold_req <= 1'h0;
        pulses = 0;
        repeat (8) begin
            @(posedge clk);
            if (led_restart === 1'h1) pulses++;
        end
        chk(32'(pulses), 32'h1);
        chk(32'(pwr_down), 32'h0);
        wb(1'h1, pcsrc_pkg::CTRL_OFFSET, 32'h8);
        cyc(6);
        chk(32'({hold_oe, hold_out, pwr_down}), 32'h7);
        wb(1'h0, pcsrc_pkg::STATUS_OFFSET, 32'h0);
        chk(rd, (32'h1 << pcsrc_pkg::STAT_HOLD_BIT) | 32'h11
            | (32'h1 << pcsrc_pkg::STAT_POWERED_DOWN_BIT));
        wb(1'h1, 4'hC, 32'h3);
        wb(1'h0, 4'h8, 32'h0);
        chk(rd, 32'h0);
        // A write without the low byte lane must leave control untouched
        sel_val = 4'hE;
        wb(1'h1, pcsrc_pkg::CTRL_OFFSET, 32'h3);
        sel_val = 4'hF;
        wb(1'h0, pcsrc_pkg::CTRL_OFFSET, 32'h0);
        chk(rd, 32'h8);
        print_verdict();
    end
endmodule
